// ### tb_timer_idle_state_trigger_out.sv
// Self-checking bench for the idle-level and trigger-output block.
// Assumes the block answers on AXI4-Lite and runs on one 25 MHz clock.
module tb_timer_idle_state_trigger_out;
  import tio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, poe = 1;
  logic [3:0] awa = 0, ara = 0, wstrb = 4'hF, cm_o;
  logic [31:0] wd = 0, rd;
  logic [1:0] rr;
  logic [2:0] pins = 0, cc_o;
  core_evt_s evt = '0;
  logic awr, wr, bv, arr, rv, tin, trigger_output;
  logic [1:0] br, rresp, wresp;
  logic [31:0] rdata;
  int n_fail = 0, total_checks = 0, edges, len, e0;
  always #20 clk = ~clk;
  tio_top i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rrdy), .CORE_EVT_I(evt), .PRIMARY_OUTPUT_ENABLE_I(poe),
    .DEADTIME_I(8'h08), .CH_MAIN_I(4'hE), .CH_COMPL_I(3'h1), .CH_PIN_I(pins),
    .CH_MAIN_O(cm_o), .CH_COMPL_O(cc_o), .FIRST_TRIG_IN_O(tin),
    .TRIGGER_OUTPUT_O(trigger_output));
  tio_slave_model i_slave (.clk_i(clk), .rst_n_i(rst_n), .trig_i(trigger_output),
    .edges_o(edges), .len_o(len));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Address and data are offered together and each is dropped once taken.
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; awv <= 1'b1; wd <= d; wv <= 1'b1; brdy <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) begin
        wresp = br;
        brdy <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rrdy <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rd = rdata;
        rr = rresp;
        rrdy <= 1'b0;
        break;
      end
    end
  endtask
  task automatic set_mode(input logic [2:0] m);
    wr_reg(OFS_CTL_TWO, 32'h0000_2900 | (32'(m) << MMS_LSB));
    waitc(4);
  endtask
  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(OFS_CTL_TWO);
    chk("ctl_reset", 32'h0, rd);
    // Software is expected to keep bit 15 clear; this probe checks it reads back 0.
    wr_reg(OFS_CTL_TWO, 32'h0000_FFFF);
    chk("wresp_ok", 32'(RESP_OKAY), 32'(wresp));
    rd_reg(OFS_CTL_TWO);
    chk("ctl_all", 32'h0000_7FF0, rd);
    wr_reg(OFS_CTL_TWO, 32'h0000_2900);
    pins <= 3'b011;
    waitc(6);
    chk("trig_pin", 32'h1, 32'(tin));
    wr_reg(OFS_CTL_TWO, 32'h0000_2980);
    waitc(6);
    chk("trig_xor", 32'h0, 32'(tin));
    @(posedge clk) poe <= 1'b0;
    waitc(5);
    chk("compl_idle", 32'h6, 32'(cc_o));
    chk("main_wait", 32'hE, 32'(cm_o));
    waitc(15);
    chk("main_idle", 32'h1, 32'(cm_o));
    wr_reg(OFS_LOCK, 32'h1);
    wr_reg(OFS_CTL_TWO, 32'h0000_0070);
    rd_reg(OFS_CTL_TWO);
    chk("locked", 32'h0000_2970, rd);
    rd_reg(OFS_STATUS);
    chk("status", 32'h0000_000B, rd);
    wr_reg(OFS_LOCK, 32'h0);
    rd_reg(4'h0);
    chk("unmapped_resp", 32'(RESP_SLVERR), 32'(rr));
    chk("unmapped_data", 32'h0, rd);
    wr_reg(4'h0, 32'h0);
    chk("unmapped_wresp", 32'(RESP_SLVERR), 32'(wresp));
    pins <= 3'b000;
    // Event modes: update bit and slave reset in 000, update 010, capture 011.
    for (int k = 0; k < 4; k++) begin
      set_mode(k < 2 ? MMS_RESET : 3'(k));
      e0 = edges;
      @(posedge clk) evt[10-k] <= 1'b1;
      @(posedge clk) evt[10-k] <= 1'b0;
      #1;
      if (k == 1) chk("reset_late", 32'h0, 32'(trigger_output));
      waitc(6);
      chk("pulse_count", 32'(e0 + 1), 32'(edges));
      chk("pulse_len", 32'h1, 32'(len));
    end
    set_mode(MMS_ENABLE);
    @(posedge clk) evt.counter_run_bit <= 1'b1;
    waitc(4);
    chk("run_enable", 32'h1, 32'(trigger_output));
    @(posedge clk) begin
      evt.counter_run_bit <= 1'b0;
      evt.pause_mode <= 1'b1;
      pins <= 3'b001;
    end
    waitc(3);
    chk("pause_lag", 32'h0, 32'(trigger_output));
    waitc(4);
    chk("pause_high", 32'h1, 32'(trigger_output));
    @(posedge clk) pins <= 3'b000;
    waitc(7);
    chk("pause_low", 32'h0, 32'(trigger_output));
    // With master-slave sync the extra clock of lag must be gone.
    @(posedge clk) begin
      evt.master_slave_sync <= 1'b1;
      pins <= 3'b001;
    end
    waitc(3);
    chk("sync_no_lag", 32'h1, 32'(trigger_output));
    @(posedge clk) begin
      evt.master_slave_sync <= 1'b0;
      evt.pause_mode <= 1'b0;
      pins <= 3'b000;
    end
    waitc(7);
    for (int k = 0; k < 4; k++) begin
      set_mode(3'(4 + k));
      @(posedge clk) evt.compare_ref <= 4'(1 << k);
      waitc(4);
      chk("ref_high", 32'h1, 32'(trigger_output));
      @(posedge clk) evt.compare_ref <= ~4'(1 << k);
      waitc(4);
      chk("ref_low", 32'h0, 32'(trigger_output));
    end
    complete_run;
  end
endmodule

// ### tio_deadtime.sv
// Dead-time delay for the main outputs moving to their idle level.
// Assumes the dead-time count is steady while the enable is cleared.
module tio_deadtime
  import tio_pkg::*;
#(
  parameter int W = DT_WIDTH
) (
  input  wire logic         clk_i,      // Timer clock.
  input  wire logic         rst_n_i,    // Synchronous reset, active low.
  input  wire logic         trig_i,     // High while outputs are idle.
  input  wire logic [W-1:0] dt_i,       // Dead-time in clocks.
  output logic              done_o      // Dead-time has elapsed.
);
  logic [W-1:0] cnt_r;
  wire          at_end = (cnt_r >= dt_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !trig_i) begin
      cnt_r <= '0;
    end else if (!at_end) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign done_o = trig_i && at_end;
endmodule

// ### tio_pkg.sv
// Package for the idle-state and trigger-output block of the advanced timer.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz timer clock.
package tio_pkg;

  localparam int          AXI_AW          = 4;
  localparam logic [3:0]  OFS_CTL_TWO     = 4'h4;  // timer_control_two
  localparam logic [3:0]  OFS_LOCK        = 4'h8;  // protection lock level
  localparam logic [3:0]  OFS_STATUS      = 4'hC;  // read-only live state
  localparam logic [15:0] CTL_TWO_RESET   = 16'h0000;
  localparam logic [15:0] CTL_TWO_WMASK   = 16'h7FF0;
  localparam logic [15:0] IDLE_BITS_MASK  = 16'h7F00;
  localparam int          MMS_LSB         = 4;
  localparam int          TIS_BIT         = 7;
  localparam int          IDLE_LSB        = 8;
  localparam logic [1:0]  LOCK_OPEN       = 2'h0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam int          DT_WIDTH        = 8;

  // Trigger-output source select values.
  localparam logic [2:0]  MMS_RESET  = 3'h0;
  localparam logic [2:0]  MMS_ENABLE = 3'h1;
  localparam logic [2:0]  MMS_UPDATE = 3'h2;
  localparam logic [2:0]  MMS_CCPULS = 3'h3;
  localparam logic [2:0]  MMS_OREF0  = 3'h4;
  localparam logic [2:0]  MMS_OREF1  = 3'h5;
  localparam logic [2:0]  MMS_OREF2  = 3'h6;
  localparam logic [2:0]  MMS_OREF3  = 3'h7;

  // Events and levels coming from the counter core and slave controller.
  typedef struct packed {
    logic       update_generate_bit;
    logic       slave_reset;
    logic       update_event;
    logic       cc0_event;
    logic       counter_run_bit;
    logic       pause_mode;
    logic       master_slave_sync;
    logic [3:0] compare_ref;
  } core_evt_s;

  // Idle levels, main then complementary, per channel.
  typedef struct packed {
    logic [3:0] main_lvl;
    logic [2:0] compl_lvl;
  } idle_lvl_s;

endpackage

// ### tio_slave_model.sv
// Slave timer stand-in that watches the trigger output of the master block.
// Assumes the trigger output is registered on the same timer clock.
module tio_slave_model
  import tio_pkg::*;
(
  input  wire logic clk_i,    // Timer clock.
  input  wire logic rst_n_i,  // Synchronous reset, active low.
  input  wire logic trig_i,   // Trigger output from the master.
  output int        edges_o,  // Rising edges seen.
  output int        len_o     // Length of the last completed high run.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_r;
  int   run_r;
  // A slave only reacts to edges and levels, so it counts both.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_r  <= 1'b0;
      run_r   <= 0;
      edges_o <= 0;
      len_o   <= 0;
    end else begin
      prev_r <= trig_i;
      run_r  <= trig_i ? run_r + 1 : 0;
      if (!trig_i && prev_r) len_o <= run_r;
      if (trig_i && !prev_r) edges_o <= edges_o + 1;
    end
  end
endmodule

// ### tio_top.sv
// Idle-state levels, channel 0 trigger input select and trigger output.
// Assumes the counter core supplies its events on the timer clock.
module tio_top
  import tio_pkg::*;
(
  input  wire logic              CORE_CLK_I,       // Timer clock, 25 MHz.
  input  wire logic              RST_N_I,          // Synchronous reset, active low.
  input  wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,   // Write address.
  input  wire logic              S_AXI_AWVALID_I,  // Write address valid.
  output logic                   S_AXI_AWREADY_O,  // Write address ready.
  input  wire logic [31:0]       S_AXI_WDATA_I,    // Write data.
  input  wire logic [3:0]        S_AXI_WSTRB_I,    // Write strobes.
  input  wire logic              S_AXI_WVALID_I,   // Write data valid.
  output logic                   S_AXI_WREADY_O,   // Write data ready.
  output logic [1:0]             S_AXI_BRESP_O,    // Write response.
  output logic                   S_AXI_BVALID_O,   // Write response valid.
  input  wire logic              S_AXI_BREADY_I,   // Write response ready.
  input  wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,   // Read address.
  input  wire logic              S_AXI_ARVALID_I,  // Read address valid.
  output logic                   S_AXI_ARREADY_O,  // Read address ready.
  output logic [31:0]            S_AXI_RDATA_O,    // Read data.
  output logic [1:0]             S_AXI_RRESP_O,    // Read response.
  output logic                   S_AXI_RVALID_O,   // Read data valid.
  input  wire logic              S_AXI_RREADY_I,   // Read data ready.
  input  wire core_evt_s         CORE_EVT_I,       // Counter core events.
  input  wire logic              PRIMARY_OUTPUT_ENABLE_I, // Outputs enabled.
  input  wire logic [DT_WIDTH-1:0] DEADTIME_I,     // Dead-time in clocks.
  input  wire logic [3:0]        CH_MAIN_I,        // Active main outputs.
  input  wire logic [2:0]        CH_COMPL_I,       // Active complementary outputs.
  input  wire logic [2:0]        CH_PIN_I,         // Channel 0..2 input pins.
  output logic [3:0]             CH_MAIN_O,        // Main outputs after idle.
  output logic [2:0]             CH_COMPL_O,       // Complementary outputs after idle.
  output logic                   FIRST_TRIG_IN_O,  // Channel 0 trigger input.
  output logic                   TRIGGER_OUTPUT_O  // Trigger output to slaves.
);

  // Register file.
  logic [15:0] ctl_two_r;
  logic [1:0]  lock_r;
  logic        aw_held_r, w_held_r;
  logic [AXI_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;

  wire aw_take  = S_AXI_AWVALID_I && awready_r;
  wire w_take   = S_AXI_WVALID_I && wready_r;
  wire have_aw  = aw_held_r || aw_take;
  wire have_w   = w_held_r || w_take;
  wire wr_fire  = have_aw && have_w && !bvalid_r;
  wire [AXI_AW-1:0] wr_addr = aw_held_r ? aw_addr_r : S_AXI_AWADDR_I;
  wire [31:0]       wr_data = w_held_r ? w_data_r : S_AXI_WDATA_I;
  wire [3:0]        wr_strb = w_held_r ? w_strb_r : S_AXI_WSTRB_I;
  wire wr_ctl   = wr_fire && (wr_addr == OFS_CTL_TWO);
  wire wr_lock  = wr_fire && (wr_addr == OFS_LOCK);
  wire wr_hit   = (wr_addr == OFS_CTL_TWO) || (wr_addr == OFS_LOCK)
                  || (wr_addr == OFS_STATUS);

  function automatic logic [15:0] strb_merge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
    logic [15:0] m;
    m = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    return m;
  endfunction

  // Idle bits are frozen unless the lock level is open; bit 15 stays reserved.
  wire [15:0] wmask   = (lock_r == LOCK_OPEN) ? CTL_TWO_WMASK
                                              : (CTL_TWO_WMASK & ~IDLE_BITS_MASK);
  wire [15:0] ctl_nxt = (ctl_two_r & ~wmask)
                        | (strb_merge(ctl_two_r, wr_data, wr_strb) & wmask);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      ctl_two_r <= CTL_TWO_RESET;
      lock_r    <= LOCK_OPEN;
    end else begin
      if (aw_take) aw_addr_r <= S_AXI_AWADDR_I;
      if (w_take) begin
        w_data_r <= S_AXI_WDATA_I;
        w_strb_r <= S_AXI_WSTRB_I;
      end
      aw_held_r <= have_aw && !wr_fire;
      w_held_r  <= have_w && !wr_fire;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
        bvalid_r <= 1'b0;
      end
      if (wr_ctl) ctl_two_r <= ctl_nxt;
      if (wr_lock && wr_strb[0]) lock_r <= wr_data[1:0];
    end
  end

  // Readies come from flip-flops fed by the next held and response state, so every
  // bus output leaves a register while the handshake timing stays the same.
  wire aw_held_nxt = have_aw && !wr_fire;
  wire w_held_nxt  = have_w && !wr_fire;
  wire bvalid_nxt  = wr_fire || (bvalid_r && !S_AXI_BREADY_I);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      awready_r <= !aw_held_nxt && !bvalid_nxt;
      wready_r  <= !w_held_nxt && !bvalid_nxt;
    end
  end

  // Read channel.
  logic [31:0] rd_mux;
  wire         ar_take = S_AXI_ARVALID_I && arready_r;
  wire         rd_hit  = (S_AXI_ARADDR_I == OFS_CTL_TWO) || (S_AXI_ARADDR_I == OFS_LOCK)
                         || (S_AXI_ARADDR_I == OFS_STATUS);
  logic [15:0] status_w;

  always_comb begin
    case (S_AXI_ARADDR_I)
      OFS_CTL_TWO: rd_mux = {16'h0000, ctl_two_r};
      OFS_LOCK:    rd_mux = {30'h0, lock_r};
      OFS_STATUS:  rd_mux = {16'h0000, status_w};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end

  wire rvalid_nxt = ar_take || (rvalid_r && !S_AXI_RREADY_I);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      arready_r <= 1'b0;
    end else begin
      arready_r <= !rvalid_nxt;
    end
  end
  assign S_AXI_AWREADY_O = awready_r;
  assign S_AXI_WREADY_O  = wready_r;
  assign S_AXI_BVALID_O  = bvalid_r;
  assign S_AXI_BRESP_O   = bresp_r;
  assign S_AXI_ARREADY_O = arready_r;
  assign S_AXI_RVALID_O  = rvalid_r;
  assign S_AXI_RDATA_O   = rdata_r;
  assign S_AXI_RRESP_O   = rresp_r;

  // Field decode.
  wire [2:0]  mms      = ctl_two_r[MMS_LSB +: 3];
  wire        tis_xor  = ctl_two_r[TIS_BIT];
  idle_lvl_s  idle;
  assign idle.main_lvl  = {ctl_two_r[IDLE_LSB+6], ctl_two_r[IDLE_LSB+4],
                           ctl_two_r[IDLE_LSB+2], ctl_two_r[IDLE_LSB]};
  assign idle.compl_lvl = {ctl_two_r[IDLE_LSB+5], ctl_two_r[IDLE_LSB+3],
                           ctl_two_r[IDLE_LSB+1]};

  // Pins are synchronised before use.
  logic [2:0] pin_s1_r, pin_s2_r, pin_used_r;
  logic       primary_output_enable_s1_r, primary_output_enable_r;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_used_r <= '0;
      primary_output_enable_s1_r <= 1'b0;
      primary_output_enable_r <= 1'b0;
    end else begin
      pin_s1_r <= CH_PIN_I;
      pin_s2_r <= pin_s1_r;
      pin_used_r <= pin_s2_r;
      primary_output_enable_s1_r <= PRIMARY_OUTPUT_ENABLE_I;
      primary_output_enable_r <= primary_output_enable_s1_r;
    end
  end

  wire trig_in = tis_xor ? ^pin_s2_r : pin_s2_r[0];

  // Dead-time before the main outputs take their idle level.
  wire dt_done;
  tio_deadtime #(.W(DT_WIDTH)) u_dt (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .trig_i  (!primary_output_enable_r),
    .dt_i    (DEADTIME_I),
    .done_o  (dt_done)
  );

  // Counter enable: run bit, or trigger input while paused. In pause mode
  // the extra flop adds lag unless master-slave sync removes it.
  logic trig_in_d_r;
  wire  pause_trig = CORE_EVT_I.master_slave_sync ? trig_in : trig_in_d_r;
  wire  cnt_en     = CORE_EVT_I.counter_run_bit
                     || (CORE_EVT_I.pause_mode && pause_trig);

  // The reset event is delayed one clock so the pulse follows the reset.
  logic slave_rst_d_r;
  wire  evt_pulse_nxt = (mms == MMS_RESET)
                        ? (CORE_EVT_I.update_generate_bit || slave_rst_d_r)
                        : CORE_EVT_I.cc0_event;
  logic trigger_output_nxt;
  always_comb begin
    case (mms)
      MMS_RESET:  trigger_output_nxt = evt_pulse_nxt;
      MMS_ENABLE: trigger_output_nxt = cnt_en;
      MMS_UPDATE: trigger_output_nxt = CORE_EVT_I.update_event;
      MMS_CCPULS: trigger_output_nxt = evt_pulse_nxt;
      MMS_OREF0:  trigger_output_nxt = CORE_EVT_I.compare_ref[0];
      MMS_OREF1:  trigger_output_nxt = CORE_EVT_I.compare_ref[1];
      MMS_OREF2:  trigger_output_nxt = CORE_EVT_I.compare_ref[2];
      MMS_OREF3:  trigger_output_nxt = CORE_EVT_I.compare_ref[3];
      default:    trigger_output_nxt = 1'b0;
    endcase
  end

  logic [3:0] main_r;
  logic [2:0] compl_r;
  logic       trig_o_r, trigger_output_r;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      trig_in_d_r   <= 1'b0;
      slave_rst_d_r <= 1'b0;
      trigger_output_r        <= 1'b0;
      trig_o_r      <= 1'b0;
      main_r        <= '0;
      compl_r       <= '0;
    end else begin
      trig_in_d_r   <= trig_in;
      slave_rst_d_r <= CORE_EVT_I.slave_reset;
      trigger_output_r        <= trigger_output_nxt;
      trig_o_r      <= trig_in;
      if (primary_output_enable_r) begin
        main_r  <= CH_MAIN_I;
        compl_r <= CH_COMPL_I;
      end else begin
        compl_r <= idle.compl_lvl;
        if (dt_done) main_r <= idle.main_lvl;
      end
    end
  end

  assign status_w = {8'h00, 1'b0, primary_output_enable_r, trigger_output_r, cnt_en, trig_o_r, pin_used_r[2:0]};
  assign CH_MAIN_O        = main_r;
  assign CH_COMPL_O       = compl_r;
  assign FIRST_TRIG_IN_O  = trig_o_r;
  assign TRIGGER_OUTPUT_O = trigger_output_r;

  // Checks.
  property p_lock;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (wr_ctl && lock_r != LOCK_OPEN) |=> $stable(ctl_two_r[14:8]);
  endproperty
  a_lock: assert property (p_lock) else $error("Idle bits changed while locked.");
  property p_bit15;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    ctl_two_r[15] == 1'b0;
  endproperty
  a_bit15: assert property (p_bit15) else $error("Reserved bit set.");
  property p_compl;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (!primary_output_enable_r && $stable(ctl_two_r)) |=> (CH_COMPL_O == idle.compl_lvl);
  endproperty
  a_compl: assert property (p_compl) else $error("Complementary idle level wrong.");
  property p_main;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (!primary_output_enable_r && dt_done && $stable(ctl_two_r)) |=> (CH_MAIN_O == idle.main_lvl);
  endproperty
  a_main: assert property (p_main) else $error("Main idle level wrong.");
  property p_dt;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    ($fell(primary_output_enable_r) && DEADTIME_I > 8'h01) |=> !dt_done;
  endproperty
  a_dt: assert property (p_dt) else $error("Dead-time skipped.");
  property p_tis;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    1'b1 |=> (FIRST_TRIG_IN_O == ($past(tis_xor) ? ^$past(pin_s2_r) : $past(pin_s2_r[0])));
  endproperty
  a_tis: assert property (p_tis) else $error("Trigger input select wrong.");
  // A slave reset seen in mode 000 is followed by the pulse two clocks later.
  sequence s_slave_rst;
    (mms == MMS_RESET) && CORE_EVT_I.slave_reset && $stable(mms);
  endsequence
  sequence s_late_pulse;
    ##2 TRIGGER_OUTPUT_O;
  endsequence
  property p_rst;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    s_slave_rst |-> s_late_pulse;
  endproperty
  a_rst: assert property (p_rst) else $error("Reset pulse not delayed correctly.");
  property p_oref;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (mms == MMS_OREF0) |=> (TRIGGER_OUTPUT_O == $past(CORE_EVT_I.compare_ref[0]));
  endproperty
  a_oref: assert property (p_oref) else $error("Compare reference not routed.");
  property p_upd;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (mms == MMS_UPDATE) |=> (TRIGGER_OUTPUT_O == $past(CORE_EVT_I.update_event));
  endproperty
  a_upd: assert property (p_upd) else $error("Update event not routed.");
endmodule
